// ### design/ccc_pkg.sv
/*
  Package for the compressor cycle controller: register map, field
  positions, reset values and timing counts.
  Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
package ccc_pkg;
  // System clock figures
  localparam int CLK_MHZ = 200; // Clock rate in MHz
  localparam int TICK_S = 1; // Tick period in seconds
  localparam int TICK_CYCLES = CLK_MHZ * 1000000 * TICK_S; // Cycles per tick

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_A_ON = 8'h04;
  localparam logic [7:0] OFS_A_OFF = 8'h08;
  localparam logic [7:0] OFS_B_ON = 8'h0C;
  localparam logic [7:0] OFS_B_OFF = 8'h10;
  localparam logic [7:0] OFS_MIN_ON = 8'h14;
  localparam logic [7:0] OFS_MIN_OFF = 8'h18;
  localparam logic [7:0] OFS_OFF_DLY = 8'h1C;
  localparam logic [7:0] OFS_IDLE = 8'h20;
  localparam logic [7:0] OFS_DEM_A = 8'h24;
  localparam logic [7:0] OFS_DEM_B = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;

  // Control field positions
  localparam int CTRL_FUNC_BIT = 0; // 1 = compressor control, 0 = off
  localparam int CTRL_A_SRC_BIT = 1; // Demand A has a source
  localparam int CTRL_B_SRC_BIT = 2; // Demand B has a source

  // Status field positions
  localparam int ST_OUT_BIT = 0;
  localparam int ST_DLY_BIT = 1;
  localparam int ST_MINON_BIT = 2;
  localparam int ST_MINOFF_BIT = 3;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h2; // Off mode, A sourced
  localparam logic signed [15:0] A_ON_RST = -16'sd20; // -2.0 %
  localparam logic signed [15:0] A_OFF_RST = 16'sd20; // 2.0 %
  localparam logic signed [15:0] B_ON_RST = -16'sd20;
  localparam logic signed [15:0] B_OFF_RST = 16'sd20;
  localparam logic [13:0] MIN_ON_RST = 14'h002D; // 45 s
  localparam logic [13:0] MIN_OFF_RST = 14'h000F; // 15 s
  localparam logic [13:0] OFF_DLY_RST = 14'h0014; // 20 s
  localparam logic [13:0] IDLE_RST = 14'h0000; // Idle shutoff off

  // Limits
  localparam logic signed [15:0] PCT_MIN = -16'sd1000; // -100.0 %
  localparam logic signed [15:0] PCT_MAX = 16'sd1000; // 100.0 %
  localparam logic [13:0] SEC_MAX = 14'd9999; // Longest time setting
endpackage

// ### design/ccc_tick_if.sv
/*
  Interface carrying the one-second tick between the tick divider and
  the controller core.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface ccc_tick_if;
  logic tick; // One-cycle pulse per second
  modport src (output tick);
  modport dst (input tick);
endinterface

// ### design/ccc_tick_gen.sv
/*
  Divider making the one-second tick from the system clock.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
module ccc_tick_gen
  import ccc_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ccc_tick_if.src tk
);
  // Divider state
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ccc_tg_t;

  ccc_tg_t s;
  ccc_tg_t next_s;

  // Count down to the end of each second
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == 32'h0) begin
      next_s.cnt = 32'(DIV - 1);
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt - 32'h1;
    end
  end

  // Registered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{cnt: 32'(DIV - 1), tick: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;
endmodule

// ### design/ccc_top.sv
/*
  Compressor cycle controller: turns one or two signed power demands
  into a single compressor run output with anti-short-cycle timing.
  Assumes an APB master on the system clock; demands are written by
  software into DEM_A and DEM_B, with control bits marking which are sourced.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic run_o,
  output logic aux_o
);
  // Controller phases
  typedef enum logic [1:0] {
    CCC_OFF, // Compressor stopped
    CCC_RUN, // Running, min on or demand holding it
    CCC_DELAY // Running out the off delay
  } ccc_phase_t;

  // Whole module state
  typedef struct packed {
    logic [2:0] ctrl;
    logic signed [15:0] a_on;
    logic signed [15:0] a_off;
    logic signed [15:0] b_on;
    logic signed [15:0] b_off;
    logic [13:0] min_on;
    logic [13:0] min_off;
    logic [13:0] off_dly;
    logic [13:0] idle;
    logic signed [15:0] dem_a;
    logic signed [15:0] dem_b;
    ccc_phase_t phase;
    logic [13:0] t_phase; // Seconds in the current on or off spell
    logic [13:0] t_dly; // Seconds of off delay so far
    logic [13:0] t_idle; // Seconds at zero power so far
    logic run;
    logic [31:0] rdata;
  } ccc_state_t;

  ccc_state_t s;
  ccc_state_t next_s;

  ccc_tick_if tk (); // One-second tick

  // Tick divider
  ccc_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk)
  );

  // Clamp a written value into the signed percent range
  function automatic logic signed [15:0] pct_clamp(
    input logic [31:0] w
  );
    logic signed [15:0] v;
    v = signed'(w[15:0]);
    if (v < PCT_MIN) begin
      pct_clamp = PCT_MIN;
    end else if (v > PCT_MAX) begin
      pct_clamp = PCT_MAX;
    end else begin
      pct_clamp = v;
    end
  endfunction

  // Clamp a seconds setting to the longest legal time
  function automatic logic [13:0] sec_clamp(input logic [31:0] w);
    if (w > 32'(SEC_MAX)) begin
      sec_clamp = SEC_MAX;
    end else begin
      sec_clamp = w[13:0];
    end
  endfunction

  // Saturating seconds counter step
  function automatic logic [13:0] sec_inc(input logic [13:0] t);
    if (t == 14'h3FFF) begin
      sec_inc = t;
    end else begin
      sec_inc = t + 14'h1;
    end
  endfunction

  // Decision terms
  logic func_on;
  logic a_src;
  logic b_src;
  logic want_on;
  logic all_off;
  logic all_zero;
  logic min_on_ok;
  logic min_off_ok;
  logic dly_done;
  logic idle_trip;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic mapped;

  assign func_on = s.ctrl[CTRL_FUNC_BIT];
  assign a_src = s.ctrl[CTRL_A_SRC_BIT];
  assign b_src = s.ctrl[CTRL_B_SRC_BIT];
  assign addr = paddr_i[7:0];
  assign wr = psel_i && penable_i && pwrite_i;
  // Read data loads in setup so it stands through the access edge
  assign rd = psel_i && !penable_i && !pwrite_i;

  // Demand and threshold comparisons
  always_comb begin
    // Any sourced input at or below its turn-on level asks to run
    want_on = (a_src && (s.dem_a <= s.a_on)) ||
              (b_src && (s.dem_b <= s.b_on));
    // No need only when every sourced input sits at or above turn-off
    all_off = (!a_src || (s.dem_a >= s.a_off)) &&
              (!b_src || (s.dem_b >= s.b_off)) &&
              (a_src || b_src);
    // Zero power on every sourced input
    all_zero = (!a_src || (s.dem_a == 16'sd0)) &&
               (!b_src || (s.dem_b == 16'sd0)) &&
               (a_src || b_src);
    min_on_ok = (s.t_phase >= s.min_on);
    min_off_ok = (s.t_phase >= s.min_off);
    dly_done = (s.t_dly >= s.off_dly);
    // Strictly longer than the idle setting; zero disables
    idle_trip = (s.idle != 14'h0) && all_zero &&
                (s.t_idle > s.idle);
  end

  // Address decode for the mapped window
  always_comb begin
    unique case (addr)
      OFS_CTRL, OFS_A_ON, OFS_A_OFF, OFS_B_ON, OFS_B_OFF,
      OFS_MIN_ON, OFS_MIN_OFF, OFS_OFF_DLY, OFS_IDLE,
      OFS_DEM_A, OFS_DEM_B, OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Next state: bus, timers and the run decision
  always_comb begin
    next_s = s;

    // Register writes; full-word writes only take effect
    if (wr && (pstrb_i == 4'hF) && (paddr_i[31:8] == 24'h0)) begin
      unique case (addr)
        OFS_CTRL: next_s.ctrl = pwdata_i[2:0];
        OFS_A_ON: next_s.a_on = pct_clamp(pwdata_i);
        OFS_A_OFF: next_s.a_off = pct_clamp(pwdata_i);
        OFS_B_ON: next_s.b_on = pct_clamp(pwdata_i);
        OFS_B_OFF: next_s.b_off = pct_clamp(pwdata_i);
        OFS_MIN_ON: next_s.min_on = sec_clamp(pwdata_i);
        OFS_MIN_OFF: next_s.min_off = sec_clamp(pwdata_i);
        OFS_OFF_DLY: next_s.off_dly = sec_clamp(pwdata_i);
        OFS_IDLE: next_s.idle = sec_clamp(pwdata_i);
        OFS_DEM_A: next_s.dem_a = pct_clamp(pwdata_i);
        OFS_DEM_B: next_s.dem_b = pct_clamp(pwdata_i);
        default: begin
          // Status and unmapped offsets ignore writes
        end
      endcase
    end

    // Read data registered on the setup edge, held until the next read
    if (rd) begin
      unique case (addr)
        OFS_CTRL: next_s.rdata = {29'h0, s.ctrl};
        OFS_A_ON: next_s.rdata = 32'(signed'(s.a_on));
        OFS_A_OFF: next_s.rdata = 32'(signed'(s.a_off));
        OFS_B_ON: next_s.rdata = 32'(signed'(s.b_on));
        OFS_B_OFF: next_s.rdata = 32'(signed'(s.b_off));
        OFS_MIN_ON: next_s.rdata = {18'h0, s.min_on};
        OFS_MIN_OFF: next_s.rdata = {18'h0, s.min_off};
        OFS_OFF_DLY: next_s.rdata = {18'h0, s.off_dly};
        OFS_IDLE: next_s.rdata = {18'h0, s.idle};
        OFS_DEM_A: next_s.rdata = 32'(signed'(s.dem_a));
        OFS_DEM_B: next_s.rdata = 32'(signed'(s.dem_b));
        OFS_STATUS: next_s.rdata = {28'h0,
            (s.phase == CCC_OFF) && !min_off_ok,
            (s.phase == CCC_RUN) && !min_on_ok,
            s.phase == CCC_DELAY, s.run};
        default: next_s.rdata = 32'h0;
      endcase
    end

    // Idle counter runs while the compressor runs and every sourced input is at zero
    if (!all_zero || !s.run || !func_on) begin
      next_s.t_idle = 14'h0;
    end else if (tk.tick) begin
      next_s.t_idle = sec_inc(s.t_idle);
    end

    // Spell timer counts seconds since the last on or off edge
    if (tk.tick) begin
      next_s.t_phase = sec_inc(s.t_phase);
    end

    if (!func_on) begin
      // Off mode keeps the compressor logic idle
      next_s.phase = CCC_OFF;
      next_s.run = 1'b0;
      next_s.t_dly = 14'h0;
    end else begin
      unique case (s.phase)
        CCC_OFF: begin
          // Start immediately once allowed
          if (want_on && min_off_ok) begin
            next_s.phase = CCC_RUN;
            next_s.run = 1'b1;
            next_s.t_phase = 14'h0;
          end
        end
        CCC_RUN: begin
          // Off request waits for min on, then enters the delay
          if (idle_trip) begin
            next_s.phase = CCC_OFF;
            next_s.run = 1'b0;
            next_s.t_phase = 14'h0;
          end else if (all_off && min_on_ok) begin
            next_s.phase = CCC_DELAY;
            next_s.t_dly = 14'h0;
          end
        end
        CCC_DELAY: begin
          if (idle_trip) begin
            next_s.phase = CCC_OFF;
            next_s.run = 1'b0;
            next_s.t_phase = 14'h0;
          end else if (!all_off) begin
            // Any demand back below turn-off holds it on
            next_s.phase = CCC_RUN;
            next_s.t_dly = 14'h0;
          end else if (dly_done) begin
            next_s.phase = CCC_OFF;
            next_s.run = 1'b0;
            next_s.t_phase = 14'h0;
          end else if (tk.tick) begin
            next_s.t_dly = sec_inc(s.t_dly);
          end
        end
      endcase
    end
  end

  // Registered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{ctrl: CTRL_RST, a_on: A_ON_RST, a_off: A_OFF_RST,
             b_on: B_ON_RST, b_off: B_OFF_RST, min_on: MIN_ON_RST,
             min_off: MIN_OFF_RST, off_dly: OFF_DLY_RST,
             idle: IDLE_RST, dem_a: 16'sh0, dem_b: 16'sh0,
             phase: CCC_OFF, t_phase: 14'h3FFF, t_dly: 14'h0,
             t_idle: 14'h0, run: 1'b0, rdata: 32'h0};
    end else begin
      s <= next_s;
    end
  end

  // Bus answer: zero-wait slave, error on unmapped or partial write
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i &&
      (!mapped || (paddr_i[31:8] != 24'h0) ||
       (pwrite_i && (pstrb_i != 4'hF)));
  assign prdata_o = s.rdata;

  // Off mode: first output follows input A's need, others inactive
  assign run_o = func_on ? s.run :
      (a_src && (s.dem_a <= s.a_on));
  assign aux_o = 1'b0;
endmodule

// ### dv/ccc_top_props.sv
/*
  Port checker for the compressor cycle controller.
  Assumes test values stay inside the clamp limits, so snooped APB
  writes equal the register contents.
*/
`timescale 1ns/1ps
module ccc_top_props
  import ccc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic run_o,
  input wire logic aux_o
);
  logic [2:0] ctrl; // Snooped control
  logic signed [15:0] a_on, a_off, dem_a; // Snooped A settings
  int mn_on, mn_off; // Snooped minimum times
  int spell; // Cycles since run_o last changed
  logic run_q;
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i && pstrb_i == 4'hF &&
    paddr_i[31:8] == 24'h0;
  // Mirror writes; spell starts large so the first start is legal
  always_ff @(posedge clk_i) begin
    run_q <= run_o;
    spell <= (run_o != run_q) ? 1 : spell + 1;
    if (rst_i) begin
      ctrl <= CTRL_RST;
      a_on <= A_ON_RST;
      a_off <= A_OFF_RST;
      dem_a <= 16'sh0;
      mn_on <= int'(MIN_ON_RST);
      mn_off <= int'(MIN_OFF_RST);
      spell <= 1000000;
    end else if (wr) begin
      case (paddr_i[7:0])
        OFS_CTRL: ctrl <= pwdata_i[2:0];
        OFS_A_ON: a_on <= pwdata_i[15:0];
        OFS_A_OFF: a_off <= pwdata_i[15:0];
        OFS_DEM_A: dem_a <= pwdata_i[15:0];
        OFS_MIN_ON: mn_on <= int'(pwdata_i[13:0]);
        OFS_MIN_OFF: mn_off <= int'(pwdata_i[13:0]);
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_aux; aux_o == 1'b0; endproperty
  a_aux: assert property (p_aux) else $error("aux high");
  property p_pass;
    !ctrl[0] |-> run_o == (ctrl[1] && dem_a <= a_on);
  endproperty
  a_pass: assert property (p_pass) else $error("no pass");
  property p_no_src; ctrl == 3'h1 && !run_o |=> !run_o; endproperty
  a_no_src: assert property (p_no_src) else $error("unsourced");
  property p_no_spur;
    ctrl[0] && !ctrl[2] && !run_o && !(ctrl[1] && dem_a <= a_on) |=> !run_o;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("spurious");
  property p_on_now;
    ctrl[2:0] == 3'h3 && !run_o && dem_a <= a_on &&
      spell > (mn_off + 1) * TICK_DIV |-> ##[1:2] run_o;
  endproperty
  a_on_now: assert property (p_on_now) else $error("late on");
  property p_hold;
    ctrl[2:0] == 3'h3 && run_o && dem_a < a_off && dem_a != 16'sh0 |=> run_o;
  endproperty
  a_hold: assert property (p_hold) else $error("early off");
  property p_min_on;
    ctrl[0] && $past(ctrl[0]) && $fell(run_o) |->
      spell >= (mn_on - 1) * TICK_DIV;
  endproperty
  a_min_on: assert property (p_min_on) else $error("short on");
  property p_min_off;
    ctrl[0] && $past(ctrl[0]) && $rose(run_o) |->
      spell >= (mn_off - 1) * TICK_DIV;
  endproperty
  a_min_off: assert property (p_min_off) else $error("short off");
endmodule

bind ccc_top ccc_top_props #(.TICK_DIV(TICK_DIV)) ccc_top_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .run_o(run_o), .aux_o(aux_o));

// ### dv/ccc_comp_model.sv
/*
  Compressor driver model: counts compressor starts.
  Assumes run_i is a level on the system clock.
*/
`timescale 1ns/1ps
module ccc_comp_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output int starts_o
);
  logic run_q; // Last sampled run level
  // Count rising edges; a real driver starts the motor on each one
  always_ff @(posedge clk_i) begin
    run_q <= run_i;
    if (rst_i) begin
      starts_o <= 0;
    end else if (run_i && !run_q) begin
      starts_o <= starts_o + 1;
    end
  end
endmodule

// ### dv/test_compressor_cycle_control.sv
/*
  Bench for the compressor cycle controller over APB.
  Assumes zero-wait APB with read data standing at the access edge.
*/
`timescale 1ns/1ps
module test_compressor_cycle_control;
  import ccc_pkg::*;
  localparam int DIV = 10; // Short tick keeps the run small
  localparam logic [31:0] NEG = 32'hFFFFFFE2; // -3.0 %
  localparam logic [31:0] POS = 32'h0000001E; // 3.0 %
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, err;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rdv;
  logic [3:0] pstrb_i;
  logic pready_o, pslverr_o, run_o, aux_o;
  int num_errors, n_checks, cycles, starts;
  logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h20, 8'h24, 8'h2C, 8'h30};
  logic [31:0] rv [10] = '{32'h2, 32'hFFFFFFEC, 32'h14, 32'h2D, 32'hF,
    32'h14, 32'h0, 32'h0, 32'h0, 32'h0};
  ccc_top #(.TICK_DIV(DIV)) ccc_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .run_o(run_o), .aux_o(aux_o));
  ccc_comp_model ccc_comp_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .run_i(run_o), .starts_o(starts));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard, well above the roughly 650 cycles needed
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_w({31'h0, g}, {31'h0, e});
  endtask
  // One APB transfer; answer taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {24'h0, a};
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    err = pslverr_o;
    rdv = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Write, then settle so outputs are looked at away from the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
    @(negedge clk_i);
  endtask
  // Idle cycles, ending on a falling edge where outputs are settled
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  // Bounded wait for run_o to reach v, landing in [lo, hi] cycles
  task automatic wait_run(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (run_o !== v && n <= hi) begin
      @(negedge clk_i);
      n++;
    end
    chk_b(n >= lo && n <= hi, 1'b1);
  endtask
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
    {paddr_i, pwdata_i, pstrb_i} = '0;
    {num_errors, n_checks, cycles} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0, 4'hF);
      chk_w(rdv, rv[i]);
      chk_b(err, ofs[i] == 8'h30);
    end
    apb(1'b1, OFS_MIN_ON, 32'h1, 4'h3);
    chk_b(err, 1'b1);
    apb(1'b0, OFS_MIN_ON, 32'h0, 4'hF);
    chk_w(rdv, 32'h2D);
    wr(OFS_A_OFF, 32'hFFFFF000);
    apb(1'b0, OFS_A_OFF, 32'h0, 4'hF);
    chk_w(rdv, 32'hFFFFFC18);
    wr(OFS_A_OFF, 32'h14);
    wr(OFS_DEM_A, NEG);
    chk_b(run_o, 1'b1);
    chk_b(aux_o, 1'b0);
    wr(OFS_DEM_A, 32'h0);
    chk_b(run_o, 1'b0);
    wr(OFS_MIN_ON, 32'h3);
    wr(OFS_MIN_OFF, 32'h4);
    wr(OFS_OFF_DLY, 32'h2);
    wr(OFS_DEM_B, 32'hFFFFFED4);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_DEM_A, NEG);
    cyc(20);
    chk_b(run_o, 1'b0);
    wr(OFS_CTRL, 32'h3);
    wait_run(1'b1, 0, 3);
    wr(OFS_DEM_A, POS);
    wait_run(1'b0, 20, 60);
    wr(OFS_DEM_A, NEG);
    cyc(20);
    chk_b(run_o, 1'b0);
    wait_run(1'b1, 3, 25);
    cyc(40);
    wr(OFS_DEM_A, POS);
    cyc(5);
    wr(OFS_DEM_A, 32'hA);
    cyc(30);
    chk_b(run_o, 1'b1);
    wr(OFS_DEM_A, 32'h14);
    wait_run(1'b0, 8, 25);
    cyc(50);
    chk_b(run_o, 1'b0);
    wr(OFS_DEM_A, NEG);
    wait_run(1'b1, 0, 3);
    wr(OFS_DEM_A, 32'h0);
    cyc(80);
    chk_b(run_o, 1'b1);
    wr(OFS_DEM_B, 32'h5);
    wr(OFS_CTRL, 32'h7);
    wr(OFS_IDLE, 32'h2);
    cyc(60);
    chk_b(run_o, 1'b1);
    wr(OFS_DEM_B, 32'h0);
    wait_run(1'b0, 15, 60);
    cyc(50);
    wr(OFS_DEM_B, NEG);
    wait_run(1'b1, 0, 3);
    wr(OFS_DEM_A, POS);
    cyc(60);
    chk_b(run_o, 1'b1);
    wr(OFS_DEM_B, POS);
    wait_run(1'b0, 8, 25);
    chk_w(starts, 32'h5);
    give_verdict();
  end
endmodule
